// >>> core/dcm_pkg.sv
package dcm_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_BYTE   = 6'h00;
  localparam logic [5:0] IDX_SHARED = 6'h01;
  localparam logic [5:0] IDX_WORD   = 6'h02;
  localparam logic [5:0] IDX_ISEL   = 6'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BY_EN   = 7;
  localparam int SH_MODE = 7;
  localparam int SH_SRC  = 6;
  localparam int SH_LOG  = 4;
  localparam int SH_SUB  = 2;
  localparam int SH_I8   = 1;
  localparam int SH_I16  = 0;
  localparam int WD_EN   = 7;
  localparam int WD_ONE  = 6;
  localparam int WD_TO   = 5;
  localparam int WD_CLK  = 3;
  localparam int WD_CAPM = 2;
  localparam int WD_CNTM = 1;
  localparam int WD_PIN  = 0;
  localparam int IS_SEL  = 6;
  localparam logic [7:0] ISEL_MASK = 8'hC0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_SHARED = 8'h00;
  localparam logic [7:0] RST_WORD   = 8'h00;
  localparam logic [7:0] RST_ISEL   = 8'h00;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LOG_AND  = 2'h0;
  localparam logic [1:0] LOG_OR   = 2'h1;
  localparam logic [1:0] LOG_NOR  = 2'h2;
  localparam logic [1:0] SUB_NORM = 2'h0;
  localparam logic [1:0] SUB_PP   = 2'h1;
  localparam logic [1:0] SUB_LOW  = 2'h2;
  localparam logic [1:0] SUB_HIGH = 2'h3;
  localparam logic [1:0] EDG_RISE = 2'h0;
  localparam logic [1:0] EDG_FALL = 2'h1;

  // ----------------------------------------------------------------
  // Glitch filter widths
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int GF1_NS = 40;
  localparam int GF2_NS = 80;
  localparam int GF3_NS = 160;
  localparam logic [7:0] GF0_CYC = 8'h01;
  localparam logic [7:0] GF1_CYC = 8'((GF1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GF2_CYC = 8'((GF2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GF3_CYC = 8'((GF3_NS + CLK_NS - 1) / CLK_NS);
endpackage

// >>> core/dcm_top.sv
// How it works
// - transmit: logic field combines both outputs
// - demodulation: logic field picks detected edge
// - submode picks ping-pong or normal operation
// - codes 10/11 force word output low/high
// - demodulation: submode sets glitch filter width
// - byte output takes initial level at start
// - idle byte output is inverse initial level
// - word output initial at start, inverse idle
// - word initial level ignored while forced
// - rising edge sets flag, write 1 clears
// - falling edge sets flag, write 1 clears
// - single-pass acts on first edge only
// - terminal count sets timeout, write 1 clears
// - capture mask enables capture interrupt
// - counter mask enables timeout interrupt
// - select routes port or word output to pin
// - clock select field drives word counter clock
// - comparator inputs interrupt on chosen edges
// - edge source is comparator A or port2 bit0
// - ping-pong hands off between both counters
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module dcm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        comparator_input_a,
  input  wire logic        comparator_input_b,
  input  wire logic        port2_bit0_input,
  input  wire logic        port3_out_value,
  input  wire logic        byte_tc,
  input  wire logic        word_tc,
  output logic             byte_counter_output,
  output logic             word_counter_output,
  output logic             timer_combined_output,
  output logic             port3_bit5_pin,
  output logic             byte_run,
  output logic             word_run,
  output logic             word_capture,
  output logic             word_reload,
  output logic      [1:0]  word_counter_clock_select,
  output logic             capture_irq,
  output logic             timeout_irq,
  output logic             comp_a_irq,
  output logic             comp_b_irq
);
  typedef struct packed {
    logic [7:0] byt;
    logic [7:0] sh;
    logic [7:0] wd;
    logic [7:0] isel;
    logic [2:0] sa;
    logic [2:0] sb;
    logic [2:0] sp;
    logic       ha;
    logic       hb;
    logic       hp;
    logic       filt;
    logic [7:0] gcnt;
    logic       armed;
    logic       en8_d;
    logic       en16_d;
    logic       o8;
    logic       o16;
    logic       ocomb;
    logic       pin;
    logic       cap;
    logic       rel;
    logic       capirq;
    logic       toirq;
    logic       airq;
    logic       birq;
    logic       ready;
    logic       slverr;
    logic [7:0] rdata;
  } dcm_state_t;

  dcm_state_t s;
  dcm_state_t next_s;
  logic       wr;
  logic       mode;
  logic [1:0] sub;
  logic [1:0] edg;
  logic [5:0] idx;
  logic       raw;
  logic [7:0] gw;
  logic       rf;
  logic       ff;
  logic       hit;
  logic       ar;
  logic       af;
  logic       br;
  logic       bf;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    mode   = s.sh[dcm_pkg::SH_MODE];
    sub    = s.sh[dcm_pkg::SH_SUB +: 2];
    edg    = s.sh[dcm_pkg::SH_LOG +: 2];
    idx    = paddr[7:2];
    wr     = psel & penable & pwrite & s.ready & !s.slverr;
    next_s.cap    = 1'b0;
    next_s.rel    = 1'b0;
    next_s.capirq = 1'b0;
    next_s.toirq  = 1'b0;
    next_s.en8_d  = s.byt[dcm_pkg::BY_EN];
    next_s.en16_d = s.wd[dcm_pkg::WD_EN];

    // Pin synchronisers: a change counts once stages two and three agree
    next_s.sa = {s.sa[1:0], comparator_input_a};
    next_s.sb = {s.sb[1:0], comparator_input_b};
    next_s.sp = {s.sp[1:0], port2_bit0_input};
    if (s.sa[2] == s.sa[1]) begin
      next_s.ha = s.sa[2];
    end
    if (s.sb[2] == s.sb[1]) begin
      next_s.hb = s.sb[2];
    end
    if (s.sp[2] == s.sp[1]) begin
      next_s.hp = s.sp[2];
    end

    // Comparator edge interrupts, edge choice shared by both inputs
    ar = !s.ha & next_s.ha;
    af = s.ha & !next_s.ha;
    br = !s.hb & next_s.hb;
    bf = s.hb & !next_s.hb;
    case (s.isel[dcm_pkg::IS_SEL +: 2])
      dcm_pkg::EDG_RISE: begin
        next_s.airq = ar;
        next_s.birq = br;
      end
      dcm_pkg::EDG_FALL: begin
        next_s.airq = af;
        next_s.birq = bf;
      end
      default: begin
        next_s.airq = ar | af;
        next_s.birq = br | bf;
      end
    endcase

    // Glitch filter; only demodulation gives the submode this meaning
    raw = s.sh[dcm_pkg::SH_SRC] ? s.ha : s.hp;
    gw  = dcm_pkg::GF0_CYC;
    if (mode) begin
      case (sub)
        2'h1:    gw = dcm_pkg::GF1_CYC;
        2'h2:    gw = dcm_pkg::GF2_CYC;
        2'h3:    gw = dcm_pkg::GF3_CYC;
        default: gw = dcm_pkg::GF0_CYC;
      endcase
    end
    if (raw == s.filt) begin
      next_s.gcnt = 8'h00;
    end else if (s.gcnt + 8'h01 >= gw) begin
      next_s.filt = raw;
      next_s.gcnt = 8'h00;
    end else begin
      next_s.gcnt = s.gcnt + 8'h01;
    end

    // Edge detector, demodulation only
    rf  = mode & !s.filt & next_s.filt & (edg != dcm_pkg::EDG_FALL);
    ff  = mode & s.filt & !next_s.filt & (edg != dcm_pkg::EDG_RISE);
    hit = rf | ff;

    // Register writes; flag bits clear only on a written 1
    if (wr) begin
      if (idx == dcm_pkg::IDX_BYTE) begin
        next_s.byt = pwdata[7:0];
      end else if (idx == dcm_pkg::IDX_SHARED) begin
        next_s.sh = pwdata[7:0];
        if (mode) begin
          next_s.sh[1:0] = s.sh[1:0] & ~pwdata[1:0];
        end
      end else if (idx == dcm_pkg::IDX_WORD) begin
        next_s.wd = pwdata[7:0];
        next_s.wd[dcm_pkg::WD_TO] = s.wd[dcm_pkg::WD_TO] & !pwdata[dcm_pkg::WD_TO];
        if (!pwdata[dcm_pkg::WD_ONE]) begin
          next_s.armed = 1'b1; // Writing 0 to single-pass rearms it
        end
      end else if (idx == dcm_pkg::IDX_ISEL) begin
        next_s.isel = pwdata[7:0] & dcm_pkg::ISEL_MASK;
      end
    end

    // Hardware sets come after the bus so a set beats a clear
    if (rf) begin
      next_s.sh[dcm_pkg::SH_I8] = 1'b1;
    end
    if (ff) begin
      next_s.sh[dcm_pkg::SH_I16] = 1'b1;
    end
    if (word_tc) begin
      next_s.wd[dcm_pkg::WD_TO] = 1'b1;
      next_s.toirq = s.wd[dcm_pkg::WD_CNTM];
    end

    // Capture and reload of the word counter
    if (mode && s.wd[dcm_pkg::WD_EN]) begin
      if (hit && (!s.wd[dcm_pkg::WD_ONE] || s.armed)) begin
        next_s.cap = 1'b1;
        next_s.rel = 1'b1;
        if (s.wd[dcm_pkg::WD_ONE]) begin
          next_s.armed = 1'b0;
        end
      end
      if (s.wd[dcm_pkg::WD_ONE] && byte_tc) begin
        next_s.cap = 1'b1; // Byte timeout captures without reload
      end
    end
    next_s.capirq = next_s.cap & s.wd[dcm_pkg::WD_CAPM];

    // Transmit output levels
    if (!mode) begin
      if (!s.byt[dcm_pkg::BY_EN]) begin
        next_s.o8 = !s.sh[dcm_pkg::SH_I8];
      end else if (!s.en8_d) begin
        next_s.o8 = s.sh[dcm_pkg::SH_I8];
      end else if (byte_tc) begin
        next_s.o8 = !s.o8;
      end
      if (sub == dcm_pkg::SUB_LOW) begin
        next_s.o16 = 1'b0;
      end else if (sub == dcm_pkg::SUB_HIGH) begin
        next_s.o16 = 1'b1;
      end else if (!s.wd[dcm_pkg::WD_EN]) begin
        next_s.o16 = !s.sh[dcm_pkg::SH_I16];
      end else if (!s.en16_d) begin
        next_s.o16 = s.sh[dcm_pkg::SH_I16];
      end else if (word_tc) begin
        next_s.o16 = !s.o16;
      end
      // Hand-off only while the code reads ping-pong, so normal ends it
      if (sub == dcm_pkg::SUB_PP) begin
        if (byte_tc && s.byt[dcm_pkg::BY_EN]) begin
          next_s.byt[dcm_pkg::BY_EN] = 1'b0;
          next_s.wd[dcm_pkg::WD_EN]  = 1'b1;
        end else if (word_tc && s.wd[dcm_pkg::WD_EN]) begin
          next_s.wd[dcm_pkg::WD_EN]  = 1'b0;
          next_s.byt[dcm_pkg::BY_EN] = 1'b1;
        end
      end
    end

    // Output combiner and pin routing
    case (edg)
      dcm_pkg::LOG_AND: next_s.ocomb = next_s.o8 & next_s.o16;
      dcm_pkg::LOG_OR:  next_s.ocomb = next_s.o8 | next_s.o16;
      dcm_pkg::LOG_NOR: next_s.ocomb = !(next_s.o8 | next_s.o16);
      default:          next_s.ocomb = !(next_s.o8 & next_s.o16);
    endcase
    next_s.pin = s.wd[dcm_pkg::WD_PIN] ? next_s.o16 : port3_out_value;

    // APB: data and answer prepared in the setup cycle, no wait states
    next_s.ready  = psel & !penable;
    next_s.slverr = 1'b0;
    next_s.rdata  = 8'h00;
    if (psel && !penable) begin
      if (paddr[1:0] != 2'h0) begin
        next_s.slverr = 1'b1;
      end else if (idx == dcm_pkg::IDX_BYTE) begin
        next_s.rdata = s.byt;
      end else if (idx == dcm_pkg::IDX_SHARED) begin
        next_s.rdata = s.sh;
      end else if (idx == dcm_pkg::IDX_WORD) begin
        next_s.rdata = s.wd;
      end else if (idx == dcm_pkg::IDX_ISEL) begin
        next_s.rdata = s.isel;
      end else begin
        next_s.slverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.byt   <= dcm_pkg::RST_BYTE;
      s.sh    <= dcm_pkg::RST_SHARED;
      s.wd    <= dcm_pkg::RST_WORD;
      s.isel  <= dcm_pkg::RST_ISEL;
      s.armed <= 1'b1;
      s.o8    <= 1'b1;
      s.o16   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign prdata                    = {24'h000000, s.rdata};
  assign pready                    = s.ready;
  assign pslverr                   = s.slverr;
  assign byte_counter_output       = s.o8;
  assign word_counter_output       = s.o16;
  assign timer_combined_output     = s.ocomb;
  assign port3_bit5_pin            = s.pin;
  assign byte_run                  = s.byt[dcm_pkg::BY_EN];
  assign word_run                  = s.wd[dcm_pkg::WD_EN];
  assign word_capture              = s.cap;
  assign word_reload               = s.rel;
  assign word_counter_clock_select = s.wd[dcm_pkg::WD_CLK +: 2];
  assign capture_irq               = s.capirq;
  assign timeout_irq               = s.toirq;
  assign comp_a_irq                = s.airq;
  assign comp_b_irq                = s.birq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcm_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_and_combine: assert property (
    !mode && edg == dcm_pkg::LOG_AND |=>
      timer_combined_output == (byte_counter_output & word_counter_output))
    else $error("combined output is not the AND of both outputs");
  chk_force_low: assert property (
    !mode && sub == dcm_pkg::SUB_LOW |=> !word_counter_output)
    else $error("word output not forced low");
  chk_byte_idle: assert property (
    !mode && !byte_run |=> byte_counter_output == !$past(s.sh[dcm_pkg::SH_I8]))
    else $error("idle byte output is not the inverse initial level");
  chk_byte_start: assert property (
    !mode && byte_run && !s.en8_d |=> byte_counter_output == $past(s.sh[dcm_pkg::SH_I8]))
    else $error("byte output missed its initial level");
  chk_rise_flag: assert property (
    rf |=> s.sh[dcm_pkg::SH_I8])
    else $error("rising edge flag not set");
  chk_flag_keep: assert property (
    mode && wr && idx == dcm_pkg::IDX_SHARED && s.sh[dcm_pkg::SH_I16]
      && !pwdata[dcm_pkg::SH_I16] |=> s.sh[dcm_pkg::SH_I16])
    else $error("falling edge flag lost on a zero write");
  chk_single_pass: assert property (
    hit && s.wd[dcm_pkg::WD_ONE] && !s.armed |=> !word_reload)
    else $error("reload on an edge after the first in single-pass");
  chk_timeout_irq: assert property (
    word_tc && s.wd[dcm_pkg::WD_CNTM] |=> timeout_irq && s.wd[dcm_pkg::WD_TO])
    else $error("timeout flag or interrupt missing");
  chk_ping_pong: assert property (
    !mode && sub == dcm_pkg::SUB_PP && byte_tc && byte_run |=> !byte_run && word_run)
    else $error("ping-pong hand-off to the word counter failed");
  chk_pin_route: assert property (
    s.wd[dcm_pkg::WD_PIN] |=> port3_bit5_pin == word_counter_output)
    else $error("pin does not follow the word output");
  chk_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");

  cov_ping_pong: cover property (byte_run ##1 word_run && !byte_run);
  cov_capture:   cover property (capture_irq);
  cov_comp_irq:  cover property (comp_a_irq);
endmodule

// >>> tb/dcm_carrier.sv
`timescale 1ns/1ps
// --------------------------------
// Carrier pins seen by the block
// --------------------------------
module dcm_carrier (
  input  wire logic clk,
  output logic      line_a,
  output logic      line_b,
  output logic      line_p2
);
  // Pins idle low; 0 selects comparator A, 1 port2 bit0, 2 comparator B
  initial begin
    line_a  = 1'b0;
    line_b  = 1'b0;
    line_p2 = 1'b0;
  end

  // Level change just after an edge; a short hold makes a glitch
  task automatic drive(input int which, input logic v, input int hold);
    @(posedge clk);
    if (which == 1) begin
      line_p2 <= v;
    end else if (which == 2) begin
      line_b <= v;
    end else begin
      line_a <= v;
    end
    repeat (hold) @(posedge clk);
  endtask

  // One clean burst: rising then falling edge
  task automatic burst(input int which);
    drive(which, 1'b1, 20);
    drive(which, 1'b0, 20);
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic        comparator_input_a, comparator_input_b, port2_bit0_input, port3_out_value;
  logic        byte_tc, word_tc, byte_counter_output, word_counter_output;
  logic        timer_combined_output, port3_bit5_pin, byte_run, word_run;
  logic        word_capture, word_reload, capture_irq, timeout_irq, comp_a_irq, comp_b_irq;
  logic [1:0]  word_counter_clock_select;
  int          mismatches, n_checks, n_cap, n_to, n_ca, c0, c1;
  int          n_cb, n_wc, n_wr, c2;
  logic [5:0]  idxs [4];
  logic [7:0]  rsts [4];

  dcm_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .comparator_input_a, .comparator_input_b, .port2_bit0_input,
    .port3_out_value, .byte_tc, .word_tc, .byte_counter_output, .word_counter_output,
    .timer_combined_output, .port3_bit5_pin, .byte_run, .word_run, .word_capture,
    .word_reload, .word_counter_clock_select, .capture_irq, .timeout_irq, .comp_a_irq,
    .comp_b_irq);

  dcm_carrier car (
    .clk     (pclk),
    .line_a  (comparator_input_a),
    .line_b  (comparator_input_b),
    .line_p2 (port2_bit0_input)
  );

  always #5 pclk = ~pclk;

  // Interrupts are one-cycle pulses, so counting them is exact
  always @(posedge pclk) begin
    if (capture_irq === 1'b1) n_cap <= n_cap + 1;
    if (timeout_irq === 1'b1) n_to <= n_to + 1;
    if (comp_a_irq === 1'b1) n_ca <= n_ca + 1;
    if (comp_b_irq === 1'b1) n_cb <= n_cb + 1;
    if (word_capture === 1'b1) n_wc <= n_wc + 1;
    if (word_reload === 1'b1) n_wr <= n_wr + 1;
  end

  // --------------------------------
  // Checking and closing
  // --------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // --------------------------------
  // Bus and pulse drivers
  // --------------------------------
  // Request held until pready is seen high; a hang ends the run
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, then let the registered outputs settle
  task automatic wreg(input logic [5:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
    repeat (2) @(posedge pclk);
  endtask

  task automatic rdchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, rd, {24'h000000, exp});
  endtask

  // Terminal count pulse of one counter
  task automatic tc(input bit is_word);
    @(posedge pclk);
    byte_tc <= !is_word;
    word_tc <= is_word;
    @(posedge pclk);
    byte_tc <= 1'b0;
    word_tc <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h00000000; port3_out_value = 0; byte_tc = 0; word_tc = 0;
    mismatches = 0; n_checks = 0; n_cap = 0; n_to = 0; n_ca = 0;
    n_cb = 0;
    n_wc = 0;
    n_wr = 0;
    idxs = '{dcm_pkg::IDX_BYTE, dcm_pkg::IDX_SHARED, dcm_pkg::IDX_WORD, dcm_pkg::IDX_ISEL};
    rsts = '{dcm_pkg::RST_BYTE, dcm_pkg::RST_SHARED, dcm_pkg::RST_WORD, dcm_pkg::RST_ISEL};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("byte out idle", byte_counter_output, 1);
    chk("word out idle", word_counter_output, 1);
    foreach (idxs[i]) rdchk("reset value", idxs[i], rsts[i]);
    apb(1'b0, 6'h03, 8'h00);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    // Transmit: byte initial 1, word initial 0, normal operation
    wreg(dcm_pkg::IDX_SHARED, 8'h02);
    chk("byte out disabled", byte_counter_output, 0);
    chk("word out disabled", word_counter_output, 1);
    wreg(dcm_pkg::IDX_BYTE, 8'h80);
    wreg(dcm_pkg::IDX_WORD, 8'h80);
    chk("byte out start", byte_counter_output, 1);
    chk("word out start", word_counter_output, 0);
    // Outputs are 1 and 0: AND, OR, NOR, NAND give 0, 1, 0, 1
    for (int lg = 0; lg < 4; lg++) begin
      wreg(dcm_pkg::IDX_SHARED, {2'b00, 2'(lg), 4'h2});
      chk("combined out", timer_combined_output, 32'(lg & 1));
    end
    // High first so that the low force is a real change
    wreg(dcm_pkg::IDX_SHARED, 8'h0E);
    chk("forced high", word_counter_output, 1);
    wreg(dcm_pkg::IDX_SHARED, 8'h0A);
    chk("forced low", word_counter_output, 0);
    // Port value opposite to the word output, so the route is visible
    port3_out_value <= 1'b1;
    wreg(dcm_pkg::IDX_WORD, 8'h99);
    chk("pin word out", port3_bit5_pin, 0);
    chk("clock select", word_counter_clock_select, 3);
    wreg(dcm_pkg::IDX_WORD, 8'h88);
    chk("pin port value", port3_bit5_pin, 1);
    chk("clock select", word_counter_clock_select, 1);
    // Counters stopped before the submode changes to ping-pong
    wreg(dcm_pkg::IDX_BYTE, 8'h00);
    wreg(dcm_pkg::IDX_WORD, 8'h00);
    wreg(dcm_pkg::IDX_SHARED, 8'h06);
    wreg(dcm_pkg::IDX_BYTE, 8'h80);
    tc(0);
    chk("pp byte stop", byte_run, 0);
    chk("pp word go", word_run, 1);
    tc(1);
    chk("pp byte go", byte_run, 1);
    chk("pp word stop", word_run, 0);
    wreg(dcm_pkg::IDX_SHARED, 8'h02);
    tc(0);
    chk("normal ends pp", byte_run, 1);
    wreg(dcm_pkg::IDX_BYTE, 8'h00);
    // Demodulation: source A, rising edge, 4-cycle filter, both masks
    wreg(dcm_pkg::IDX_WORD, 8'hA6);
    wreg(dcm_pkg::IDX_SHARED, 8'hC4);
    c0 = n_cap;
    car.drive(0, 1'b1, 2);
    car.drive(0, 1'b0, 20);
    rdchk("glitch flags", dcm_pkg::IDX_SHARED, 8'hC4);
    chk("glitch capture", n_cap - c0, 0);
    car.drive(0, 1'b1, 20);
    rdchk("rise flag", dcm_pkg::IDX_SHARED, 8'hC6);
    chk("capture irq", n_cap - c0, 1);
    wreg(dcm_pkg::IDX_SHARED, 8'hC4);
    rdchk("flag kept", dcm_pkg::IDX_SHARED, 8'hC6);
    wreg(dcm_pkg::IDX_SHARED, 8'hC6);
    rdchk("rise cleared", dcm_pkg::IDX_SHARED, 8'hC4);
    car.drive(0, 1'b0, 20);
    chk("fall ignored", n_cap - c0, 1);
    wreg(dcm_pkg::IDX_SHARED, 8'hD7);
    car.burst(0);
    apb(1'b0, dcm_pkg::IDX_SHARED, 8'h00);
    chk("fall flag", rd & 1, 1);
    chk("fall capture", n_cap - c0, 2);
    wreg(dcm_pkg::IDX_SHARED, 8'hD5);
    apb(1'b0, dcm_pkg::IDX_SHARED, 8'h00);
    chk("fall cleared", rd & 1, 0);
    // Both edges: single pass takes one, single pass off takes all
    wreg(dcm_pkg::IDX_SHARED, 8'hE7);
    wreg(dcm_pkg::IDX_WORD, 8'hC6);
    c0 = n_cap;
    c1 = n_wc;
    c2 = n_wr;
    car.burst(0);
    chk("single pass", n_cap - c0, 1);
    chk("single reload", n_wr - c2, 1);
    // Byte timeout in single pass captures but never reloads
    tc(0);
    chk("byte timeout capture", n_wc - c1, 2);
    chk("byte timeout no reload", n_wr - c2, 1);
    wreg(dcm_pkg::IDX_WORD, 8'h86);
    car.burst(0);
    chk("every edge", n_cap - c0, 4);
    chk("every reload", n_wr - c2, 3);
    // Source port2; comparator A still raises its own interrupt
    wreg(dcm_pkg::IDX_SHARED, 8'hA4);
    c0 = n_cap;
    c1 = n_ca;
    car.burst(0);
    chk("source A unused", n_cap - c0, 0);
    chk("comp rise only", n_ca - c1, 1);
    car.burst(1);
    chk("source p2", n_cap - c0, 2);
    wreg(dcm_pkg::IDX_ISEL, 8'h80);
    car.burst(0);
    chk("comp both", n_ca - c1, 3);
    c2 = n_cb;
    car.burst(2);
    chk("comp b both", n_cb - c2, 2);
    // Timeout flag and its interrupt
    c0 = n_to;
    tc(1);
    rdchk("timeout set", dcm_pkg::IDX_WORD, 8'hA6);
    chk("timeout irq", n_to - c0, 1);
    wreg(dcm_pkg::IDX_WORD, 8'h86);
    rdchk("timeout kept", dcm_pkg::IDX_WORD, 8'hA6);
    wreg(dcm_pkg::IDX_WORD, 8'hA6);
    rdchk("timeout cleared", dcm_pkg::IDX_WORD, 8'h86);
    report_and_stop();
  end
endmodule
